// file: design/bwpc_pkg.sv
package bwpc_pkg;

    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int WAKE_MAX = 7;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_LATCH_EN = 8'h04;
    localparam logic [7:0] OFF_LATCH_CLR = 8'h08;
    localparam logic [7:0] OFF_INPUT_EN = 8'h0c;
    localparam logic [7:0] OFF_POLARITY = 8'h14;
    localparam logic [7:0] OFF_RISE = 8'h18;
    localparam logic [7:0] OFF_FALL = 8'h1c;
    localparam logic [7:0] OFF_BUFFER_EN = 8'h20;

    // Control register fields
    localparam int CTRL_STATUS_LSB = 0;
    localparam int CTRL_OVR_STATUS = 8;
    localparam int CTRL_FW_LEVEL = 9;
    localparam int CTRL_FW_TAKEOVER = 10;
    localparam int CTRL_FILTER_BYPASS = 11;
    localparam int CTRL_OUT_STATE = 12;
    localparam int CTRL_RAIL_GOOD = 13;

    // Override position in the enable registers
    localparam int OVR_BIT = 7;

    // Reset values
    localparam logic [7:0] INPUT_EN_RST = 8'hff;
    localparam logic [7:0] BUFFER_EN_RST = 8'h00;
    localparam logic [7:0] POLARITY_RST = 8'h00;
    localparam logic [7:0] LATCH_EN_RST = 8'h00;
    localparam logic CTRL_BIT_RST = 1'h0;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int FILTER_TIME_NS = 1000;
    localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bwpc_bus_req_s;

endpackage : bwpc_pkg

// file: design/bwpc_wake_ctrl.sv
// Function
// - Enabled asserted wake inputs raise output
// - Weekly alarm raises output
// - Calendar alarm raises output
// - Inputs active low; per-pin polarity bit
// - Disabled input never affects output
// - Status shows buffered input levels, ORed with latches
// - Glitch filters on; one bypass bit
// - Latched assertion held until latch reset
// - Sticky rising and falling edge bits
// - Both enables zero turns buffer off
// - Takeover plus rail good gives firmware control
// - Firmware level bit drives output
// - Rail low forces hardware control
// - Wake interrupts need the core rail
// - Override active high, gated interrupt
// - Battery reset defaults everything
// - System reset isolates port and gates interrupts
// - Logic runs continuously, no low power
// - Registers only on controller port
// - Up to seven wake inputs
// - Filter, edge, polarity, then latch
// - Edge detection only with buffer on
// - Rail loss returns control to hardware
`timescale 1ns/100ps
module bwpc_wake_ctrl #(
    parameter int WAKE_N = 4,
    parameter int FILTER_CYCLES = bwpc_pkg::FILTER_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic system_isolation_reset_i,
    input wire bwpc_pkg::bwpc_bus_req_s bus_i,
    output logic [bwpc_pkg::DATA_W-1:0] rdata_o,
    input wire logic [WAKE_N-1:0] wake_input_n_i,
    input wire logic override_input_i,
    input wire logic week_alarm_i,
    input wire logic clock_alarm_signal_i,
    input wire logic main_rail_good_i,
    input wire logic core_rail_good_i,
    output logic power_enable_output_o,
    output logic [WAKE_N-1:0] wake_irq_o,
    output logic override_irq_o
);

    localparam int CNT_W = (FILTER_CYCLES > 1) ? $clog2(FILTER_CYCLES) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FILTER_CYCLES - 1);
    localparam logic [7:0] WAKE_MASK = 8'((1 << WAKE_N) - 1);
    localparam logic [7:0] EN_MASK = WAKE_MASK | 8'h80;

    logic [7:0] input_en_reg;
    logic [7:0] buffer_en_reg;
    logic [7:0] polarity_reg;
    logic [7:0] latch_en_reg;
    logic fw_level_reg;
    logic takeover_reg;
    logic bypass_reg;
    logic [WAKE_N-1:0] latch_reg;
    logic [WAKE_N-1:0] latch_next;
    logic [WAKE_N-1:0] rise_reg;
    logic [WAKE_N-1:0] rise_next;
    logic [WAKE_N-1:0] fall_reg;
    logic [WAKE_N-1:0] fall_next;
    logic power_enable_reg;
    logic power_enable_next;
    logic [bwpc_pkg::DATA_W-1:0] rdata_reg;
    logic [bwpc_pkg::DATA_W-1:0] rdata_next;
    logic [WAKE_N-1:0] wake_irq_reg;
    logic override_irq_reg;

    logic [WAKE_N-1:0] buf_on;
    logic [WAKE_N-1:0] filt;
    logic [WAKE_N-1:0] rise_set;
    logic [WAKE_N-1:0] fall_set;
    logic [WAKE_N-1:0] asserted;
    logic [WAKE_N-1:0] status;
    logic [WAKE_N-1:0] latch_clr;
    logic [WAKE_N-1:0] rise_clr;
    logic [WAKE_N-1:0] fall_clr;
    logic override_level;
    logic hw_comb;
    logic fw_mode;
    logic wr_ok;
    logic rd_ok;

    // Port isolated while the system reset is high
    assign wr_ok = bus_i.wr && !system_isolation_reset_i;
    assign rd_ok = bus_i.rd && !system_isolation_reset_i;

    // Per-input chain: filter, edge, polarity, latch
    genvar gi;
    generate
        for (gi = 0; gi < WAKE_N; gi++) begin : g_wake
            logic raw;
            logic filt_reg;
            logic prev_reg;
            logic buf_d_reg;
            logic [CNT_W-1:0] cnt_reg;

            assign buf_on[gi] = input_en_reg[gi] | buffer_en_reg[gi];
            // Buffer off reads as the not-asserted level
            assign raw = buf_on[gi] ? wake_input_n_i[gi] : ~polarity_reg[gi];

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    filt_reg <= 1'h1;
                    cnt_reg <= '0;
                end else if (bypass_reg) begin
                    filt_reg <= raw;
                    cnt_reg <= '0;
                end else if (raw == filt_reg) begin
                    cnt_reg <= '0;
                end else if (cnt_reg == CNT_LAST) begin
                    filt_reg <= raw;
                    cnt_reg <= '0;
                end else begin
                    cnt_reg <= cnt_reg + CNT_W'(1);
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    prev_reg <= 1'h1;
                    buf_d_reg <= 1'h0;
                end else begin
                    prev_reg <= filt_reg;
                    buf_d_reg <= buf_on[gi];
                end
            end

            assign filt[gi] = filt_reg;
            // Edges taken before polarity, only with buffer on
            assign rise_set[gi] = buf_on[gi] & buf_d_reg & ~prev_reg & filt_reg;
            assign fall_set[gi] = buf_on[gi] & buf_d_reg & prev_reg & ~filt_reg;
            assign asserted[gi] = polarity_reg[gi] ? filt_reg : ~filt_reg;
        end
    endgenerate

    assign status = asserted | latch_reg;
    assign override_level = (input_en_reg[bwpc_pkg::OVR_BIT]
        | buffer_en_reg[bwpc_pkg::OVR_BIT]) & override_input_i;

    // Hardware combination of every wake source
    assign hw_comb = (|(input_en_reg[WAKE_N-1:0] & status))
        | (input_en_reg[bwpc_pkg::OVR_BIT] & override_level)
        | week_alarm_i
        | clock_alarm_signal_i;
    assign fw_mode = takeover_reg & main_rail_good_i;
    assign power_enable_next = fw_mode ? fw_level_reg : hw_comb;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_enable_reg <= 1'h0;
        end else begin
            power_enable_reg <= power_enable_next;
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            input_en_reg <= bwpc_pkg::INPUT_EN_RST & EN_MASK;
            buffer_en_reg <= bwpc_pkg::BUFFER_EN_RST;
            polarity_reg <= bwpc_pkg::POLARITY_RST;
            latch_en_reg <= bwpc_pkg::LATCH_EN_RST;
        end else if (wr_ok) begin
            case (bus_i.addr)
                bwpc_pkg::OFF_INPUT_EN: input_en_reg <= bus_i.wdata[7:0] & EN_MASK;
                bwpc_pkg::OFF_BUFFER_EN: buffer_en_reg <= bus_i.wdata[7:0] & EN_MASK;
                bwpc_pkg::OFF_POLARITY: polarity_reg <= bus_i.wdata[7:0] & WAKE_MASK;
                bwpc_pkg::OFF_LATCH_EN: latch_en_reg <= bus_i.wdata[7:0] & WAKE_MASK;
                default: ;
            endcase
        end
    end

    // Control bits; takeover drops with the rail
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fw_level_reg <= bwpc_pkg::CTRL_BIT_RST;
            takeover_reg <= bwpc_pkg::CTRL_BIT_RST;
            bypass_reg <= bwpc_pkg::CTRL_BIT_RST;
        end else begin
            if (wr_ok && bus_i.addr == bwpc_pkg::OFF_CTRL) begin
                fw_level_reg <= bus_i.wdata[bwpc_pkg::CTRL_FW_LEVEL];
                takeover_reg <= bus_i.wdata[bwpc_pkg::CTRL_FW_TAKEOVER];
                bypass_reg <= bus_i.wdata[bwpc_pkg::CTRL_FILTER_BYPASS];
            end
            if (!main_rail_good_i) begin
                takeover_reg <= 1'h0;
            end
        end
    end

    // Write-one clears; a set in the same cycle wins
    assign latch_clr = (wr_ok && bus_i.addr == bwpc_pkg::OFF_LATCH_CLR) ?
        bus_i.wdata[WAKE_N-1:0] : '0;
    assign rise_clr = (wr_ok && bus_i.addr == bwpc_pkg::OFF_RISE) ?
        bus_i.wdata[WAKE_N-1:0] : '0;
    assign fall_clr = (wr_ok && bus_i.addr == bwpc_pkg::OFF_FALL) ?
        bus_i.wdata[WAKE_N-1:0] : '0;
    assign latch_next = (latch_reg & ~latch_clr) | (asserted & latch_en_reg[WAKE_N-1:0]);
    assign rise_next = (rise_reg & ~rise_clr) | rise_set;
    assign fall_next = (fall_reg & ~fall_clr) | fall_set;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_reg <= '0;
        end else begin
            latch_reg <= latch_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rise_reg <= '0;
            fall_reg <= '0;
        end else begin
            rise_reg <= rise_next;
            fall_reg <= fall_next;
        end
    end

    // Interrupt levels only with the core rail up and port not isolated
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_irq_reg <= '0;
            override_irq_reg <= 1'h0;
        end else if (core_rail_good_i && !system_isolation_reset_i) begin
            wake_irq_reg <= asserted;
            override_irq_reg <= override_level;
        end else begin
            wake_irq_reg <= '0;
            override_irq_reg <= 1'h0;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdata_next = '0;
        if (rd_ok) begin
            case (bus_i.addr)
                bwpc_pkg::OFF_CTRL: begin
                    rdata_next[bwpc_pkg::CTRL_STATUS_LSB +: WAKE_N] = status;
                    rdata_next[bwpc_pkg::CTRL_OVR_STATUS] = override_level;
                    rdata_next[bwpc_pkg::CTRL_FW_LEVEL] = fw_level_reg;
                    rdata_next[bwpc_pkg::CTRL_FW_TAKEOVER] = takeover_reg;
                    rdata_next[bwpc_pkg::CTRL_FILTER_BYPASS] = bypass_reg;
                    rdata_next[bwpc_pkg::CTRL_OUT_STATE] = power_enable_reg;
                    rdata_next[bwpc_pkg::CTRL_RAIL_GOOD] = main_rail_good_i;
                end
                bwpc_pkg::OFF_LATCH_EN: rdata_next[7:0] = latch_en_reg;
                bwpc_pkg::OFF_INPUT_EN: rdata_next[7:0] = input_en_reg;
                bwpc_pkg::OFF_POLARITY: rdata_next[7:0] = polarity_reg;
                bwpc_pkg::OFF_RISE: rdata_next[WAKE_N-1:0] = rise_reg;
                bwpc_pkg::OFF_FALL: rdata_next[WAKE_N-1:0] = fall_reg;
                bwpc_pkg::OFF_BUFFER_EN: rdata_next[7:0] = buffer_en_reg;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign power_enable_output_o = power_enable_reg;
    assign wake_irq_o = wake_irq_reg;
    assign override_irq_o = override_irq_reg;

    // Checks
    fw_drive_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (takeover_reg && main_rail_good_i) |=> power_enable_output_o == $past(fw_level_reg))
        else $error("Output does not follow firmware level");

    rail_low_hw_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !main_rail_good_i |=> power_enable_output_o == $past(hw_comb))
        else $error("Output not under hardware control with rail low");

    week_alarm_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (week_alarm_i && !fw_mode) |=> power_enable_output_o)
        else $error("Weekly alarm did not raise output");

    clock_alarm_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (clock_alarm_signal_i && !fw_mode) |=> power_enable_output_o)
        else $error("Calendar alarm did not raise output");

    latch_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (latch_reg[WAKE_N-1] && !latch_clr[WAKE_N-1]) |=> latch_reg[WAKE_N-1]
        ##1 (latch_reg[WAKE_N-1] || $past(latch_clr[WAKE_N-1])))
        else $error("Latched assertion lost without reset");

    fall_edge_seen_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(filt[0]) && buf_on[0] && $past(buf_on[0]) |=> fall_reg[0])
        else $error("Falling edge not recorded");

    irq_rail_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !core_rail_good_i |=> (wake_irq_o == '0) && !override_irq_o)
        else $error("Interrupt raised without core rail");

    bus_isolate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (system_isolation_reset_i && bus_i.rd) |=> rdata_o == '0)
        else $error("Read answered while isolated");

    takeover_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !main_rail_good_i |=> !takeover_reg)
        else $error("Takeover kept after rail loss");

    reset_default_a: assert property (@(posedge clk_i)
        rst_i |=> !power_enable_output_o && latch_reg == '0 && rise_reg == '0)
        else $error("Battery reset left state set");

    disabled_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!buf_on[0] && !bypass_reg) |-> ##1 !rise_set[0])
        else $error("Disabled input produced an edge");

    wake_pin_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (input_en_reg[0] && asserted[0] && !fw_mode) |=> power_enable_output_o)
        else $error("Enabled asserted input did not raise output");

    active_high_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (polarity_reg[0] && filt[0] && input_en_reg[0] && !fw_mode) |=> power_enable_output_o)
        else $error("Active-high input did not raise output");

    override_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (input_en_reg[bwpc_pkg::OVR_BIT] && override_input_i && !fw_mode)
        |=> power_enable_output_o)
        else $error("Override input did not raise output");

    latch_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (asserted[WAKE_N-1] && latch_en_reg[WAKE_N-1]) |=> latch_reg[WAKE_N-1])
        else $error("Enabled latch did not capture assertion");

    rise_edge_seen_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(filt[0]) && buf_on[0] && $past(buf_on[0]) |=> rise_reg[0])
        else $error("Rising edge not recorded");

    edge_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rise_reg[0] && !rise_clr[0]) |=> rise_reg[0])
        else $error("Rising edge bit lost without clear");

    filter_flip_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!$past(rst_i) && !$past(bypass_reg) && $changed(filt[0]))
        |-> $past(g_wake[0].cnt_reg) == CNT_LAST)
        else $error("Filter passed a change too early");

    irq_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (core_rail_good_i && !system_isolation_reset_i) |=> wake_irq_o == $past(asserted))
        else $error("Wake interrupt does not follow input");

    irq_isolate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        system_isolation_reset_i |=> (wake_irq_o == '0) && !override_irq_o)
        else $error("Interrupt raised while isolated");

    iso_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (system_isolation_reset_i && bus_i.wr) |=> $stable(polarity_reg)
        && $stable(input_en_reg) && $stable(buffer_en_reg) && $stable(latch_en_reg))
        else $error("Write landed while isolated");

    status_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_ok && bus_i.addr == bwpc_pkg::OFF_CTRL)
        |=> rdata_o[bwpc_pkg::CTRL_STATUS_LSB +: WAKE_N] == $past(status))
        else $error("Status read does not show input levels");

    reset_config_a: assert property (@(posedge clk_i)
        rst_i |=> input_en_reg == (bwpc_pkg::INPUT_EN_RST & EN_MASK)
        && polarity_reg == bwpc_pkg::POLARITY_RST && !takeover_reg && fall_reg == '0)
        else $error("Battery reset left configuration set");

endmodule : bwpc_wake_ctrl

// file: bench/bwpc_partner.sv
`timescale 1ns/100ps
module bwpc_partner #(
    parameter int WAKE_N = 4,
    parameter int RAIL_DLY = 3
) (
    input wire logic clk_i,
    input wire logic [WAKE_N-1:0] press_i,
    input wire logic power_enable_output_i,
    output logic [WAKE_N-1:0] wake_input_n_o,
    output logic main_rail_good_o
);
    logic [RAIL_DLY-1:0] ramp_reg = '0;
    // Released buttons fall back to the pull-up
    assign wake_input_n_o = ~press_i;
    // Regulator ramps its rail some cycles after the enable
    always_ff @(posedge clk_i) begin
        ramp_reg <= {ramp_reg[RAIL_DLY-2:0], power_enable_output_i};
    end
    assign main_rail_good_o = ramp_reg[RAIL_DLY-1];
endmodule : bwpc_partner

// file: bench/testbench.sv
`timescale 1ns/100ps
module testbench;
    localparam int WN = 4;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic iso = 1'b0;
    logic core = 1'b1;
    logic [2:0] alarm = 3'h0;
    logic [WN-1:0] press = '0;
    bwpc_pkg::bwpc_bus_req_s bus = '0;
    logic [31:0] rdata;
    logic [WN-1:0] pins_n;
    logic [WN-1:0] irq;
    logic ovr_irq;
    logic pwr;
    logic rail;
    int failures = 0;
    int comparisons = 0;

    bwpc_wake_ctrl #(.WAKE_N(WN), .FILTER_CYCLES(4)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .system_isolation_reset_i(iso), .bus_i(bus),
        .rdata_o(rdata), .wake_input_n_i(pins_n), .override_input_i(alarm[2]),
        .week_alarm_i(alarm[0]), .clock_alarm_signal_i(alarm[1]),
        .main_rail_good_i(rail), .core_rail_good_i(core),
        .power_enable_output_o(pwr), .wake_irq_o(irq), .override_irq_o(ovr_irq)
    );
    bwpc_partner #(.WAKE_N(WN)) i_partner (
        .clk_i(clk_i), .press_i(press), .power_enable_output_i(pwr),
        .wake_input_n_o(pins_n), .main_rail_good_o(rail)
    );

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check_reg(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check_reg

    task automatic check_bit(input string name, input logic seen, input logic exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %b seen %b", name, exp, seen);
        end
    endtask : check_bit

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1;
        check_reg($sformatf("reg %h", a), rdata, exp);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : idle

    task automatic wait_out(input logic exp);
        int n;
        n = 0;
        while (pwr !== exp && n < 40) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check_bit("power output", pwr, exp);
    endtask : wait_out

    task automatic blip(input int pin);
        @(posedge clk_i);
        press[pin] <= 1'b1;
        idle(2);
        press[pin] <= 1'b0;
    endtask : blip

    initial begin
        #100us;
        failures++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h0c, 32'h8f);
        rd(8'h14, 32'h0);
        rd(8'h20, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h00, 32'h0);
        rd(8'h10, 32'h0);
        check_bit("power output", pwr, 1'b0);
        // Button press wakes the rail
        press[0] <= 1'b1;
        wait_out(1'b1);
        idle(6);
        rd(8'h00, 32'h3001);
        rd(8'h1c, 32'h1);
        check_bit("wake irq", irq[0], 1'b1);
        core <= 1'b0;
        idle(3);
        check_bit("wake irq gated", irq[0], 1'b0);
        core <= 1'b1;
        iso <= 1'b1;
        rd(8'h00, 32'h0);
        wr(8'h14, 32'hf);
        iso <= 1'b0;
        rd(8'h14, 32'h0);
        check_bit("power output", pwr, 1'b1);
        // Firmware holds the rail, then drops it
        wr(8'h00, 32'h600);
        press[0] <= 1'b0;
        idle(12);
        check_bit("power output", pwr, 1'b1);
        rd(8'h18, 32'h1);
        wr(8'h00, 32'h400);
        wait_out(1'b0);
        idle(8);
        check_bit("power output", pwr, 1'b0);
        rd(8'h00, 32'h0);
        wr(8'h18, 32'hf);
        wr(8'h1c, 32'hf);
        // Pin monitored but not driving the output
        wr(8'h0c, 32'h8e);
        wr(8'h20, 32'h1);
        press[0] <= 1'b1;
        idle(12);
        check_bit("power output", pwr, 1'b0);
        rd(8'h00, 32'h1);
        wr(8'h20, 32'h0);
        wr(8'h1c, 32'hf);
        press[0] <= 1'b0;
        idle(12);
        rd(8'h00, 32'h0);
        rd(8'h18, 32'h0);
        wr(8'h0c, 32'h8f);
        // Active-high pin idles asserted
        wr(8'h14, 32'h2);
        wait_out(1'b1);
        wr(8'h14, 32'h0);
        wait_out(1'b0);
        // Short glitch only passes with the filter bypassed
        blip(2);
        idle(12);
        rd(8'h1c, 32'h0);
        wr(8'h00, 32'h800);
        blip(2);
        idle(4);
        rd(8'h1c, 32'h4);
        wr(8'h00, 32'h0);
        wr(8'h1c, 32'hf);
        wr(8'h18, 32'hf);
        idle(8);
        // Latched press survives release until cleared
        wr(8'h04, 32'h8);
        press[3] <= 1'b1;
        idle(10);
        press[3] <= 1'b0;
        idle(12);
        check_bit("power output", pwr, 1'b1);
        rd(8'h00, 32'h3008);
        wr(8'h08, 32'h8);
        wait_out(1'b0);
        // Week alarm, clock alarm, override
        for (int k = 0; k < 3; k++) begin
            alarm <= 3'h1 << k;
            wait_out(1'b1);
            idle(2);
            check_bit("override irq", ovr_irq, (k == 2));
            alarm <= 3'h0;
            wait_out(1'b0);
            idle(6);
        end
        // Battery reset mid-run clears configuration and latches
        wr(8'h04, 32'h1);
        wr(8'h14, 32'h1);
        wait_out(1'b1);
        rst_i <= 1'b1;
        idle(2);
        rst_i <= 1'b0;
        rd(8'h14, 32'h0);
        rd(8'h04, 32'h0);
        check_bit("power output", pwr, 1'b0);
        finish_test();
    end
endmodule : testbench
